/* File: verilog/burner_start_sequencer.sv */
// burner start sequencer with axi4-lite register access
//
// Contract
// - heat demand switches on burner motor and ignition to start.
// - without damper monitoring pre-purge starts at once, else after damper open.
// - after 30 s pre-purge drop damper hold, wait for damper-minimum if monitored.
// - without damper monitoring continue straight on and open first-stage valve.
// - flame seen after fuel release lets sequence go to post-ignition and high flame.
// - high-flame release powers demand; damper opens first, second valve after maximum.
// - after high flame handling stay in run until demand change or fault.
// - no flame after fuel release closes fuel, lockout within 5 s.
// - lockout lights lamp, stays until local or remote reset.
// - after reset from lockout, new start once safety interval has ended.
// - repeat-cycle: flame loss closes fuel at once and restarts sequence.
// - direct-lockout: flame loss locks out at once, restart only after reset.
// - pre-ignition 30 s or 2 s; short ignition starts at end of pre-purge.
// - safety 5 s, post-ignition 7.5 s, second stage 11.5 s, no reset delay; the code waits the 5 s safety interval after reset.
// - cut mode strap gives repeat-cycle; external link forces direct lockout.
// - damper monitoring modes none, maximum, minimum, both, from straps.
// - missing expected damper end feedback leads to lockout.
// - cut timeout strap: missing damper feedback causes no lockout.
// - remote reset input beside local button, remote lockout indicator output.
// - damper feedback must arrive within 60 s, else lockout.
// - flame during pre-purge is stray light: lockout before fuel.
// - lockout kept through supply loss; otherwise restoration starts normally.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module burner_start_sequencer #(
  parameter int TICK_CYCLES = burner_pkg::TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic heat_demand,
  input wire logic flame_present,
  input wire logic damper_max,
  input wire logic damper_min,
  input wire logic high_flame_request,
  input wire logic reset_button,
  input wire logic remote_reset,
  input wire logic supply_ok,
  output logic motor_hold_relay,
  output logic ignition,
  output logic damper_open_cmd,
  output logic first_stage_valve,
  output logic second_stage_valve,
  output logic high_flame_enable,
  output logic lockout_relay,
  output logic remote_lockout_lamp
);
  import burner_pkg::*;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [23:0] tick_cnt;
    logic tick;
    logic [9:0] t;
    seq_state_t st;
    logic [5:0] cfg;
    logic sw_reset;
    logic motor;
    logic ign;
    logic dcmd;
    logic v1;
    logic v2;
    logic hf_en;
    logic lamp;
    logic aw_ok;
    logic [3:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t r;
  state_t next_r;
  seq_state_t ns;
  logic dem, flame, dmax, dmin, hfreq, pwr, rst_any;
  logic max_mon, min_mon, recycle, tmo, short_pi, running;

  // ----------------------------------------------------------------
  // decoded inputs and strap settings
  // ----------------------------------------------------------------
  assign dem = r.s2[IN_DEMAND];
  assign flame = r.s2[IN_FLAME];
  assign dmax = r.s2[IN_DMAX];
  assign dmin = r.s2[IN_DMIN];
  assign hfreq = r.s2[IN_HFREQ];
  assign pwr = r.s2[IN_SUPPLY];
  assign rst_any = r.s2[IN_BUTTON] | r.s2[IN_REMOTE] | r.sw_reset;
  assign max_mon = r.cfg[CFG_DAMPER_LO];
  assign min_mon = r.cfg[CFG_DAMPER_LO+1];
  assign recycle = r.cfg[CFG_RECYCLE_CUT] & ~r.cfg[CFG_DIRECT_LINK];
  assign short_pi = r.cfg[CFG_SHORT_PREIGN];
  assign tmo = (r.t >= DAMPER_TICKS) & ~r.cfg[CFG_TMO_DISABLE];
  assign running = (r.st == ST_POSTIGN) | (r.st == ST_RUN) | (r.st == ST_HF_OPEN) |
                   (r.st == ST_HIGH);

  // ----------------------------------------------------------------
  // next state of everything
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    // two-stage input synchronisers
    next_r.s1 = {supply_ok, remote_reset, reset_button, high_flame_request,
                 damper_min, damper_max, flame_present, heat_demand};
    next_r.s2 = r.s1;
    // single timebase tick for all intervals
    next_r.tick = 1'b0;
    if (r.tick_cnt >= 24'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = 24'h000000;
      next_r.tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 24'h000001;
    end
    if (r.tick && r.t != 10'h3ff) begin
      next_r.t = r.t + 10'h001;
    end
    next_r.sw_reset = 1'b0;

    // sequencer
    ns = r.st;
    unique case (r.st)
      ST_IDLE: begin
        if (dem) begin
          ns = max_mon ? ST_WAIT_OPEN : ST_PREPURGE;
        end
      end
      ST_WAIT_OPEN: begin
        if (dmax) begin
          ns = ST_PREPURGE;
        end else if (tmo) begin
          ns = ST_LOCKOUT;
        end
      end
      ST_PREPURGE: begin
        if (flame) begin
          ns = ST_LOCKOUT;
        end else if (r.t >= PREPURGE_TICKS) begin
          if (min_mon) begin
            ns = ST_WAIT_MIN;
          end else begin
            ns = short_pi ? ST_PREIGN : ST_SAFETY;
          end
        end
      end
      ST_WAIT_MIN: begin
        if (flame) begin
          ns = ST_LOCKOUT;
        end else if (dmin) begin
          ns = short_pi ? ST_PREIGN : ST_SAFETY;
        end else if (tmo) begin
          ns = ST_LOCKOUT;
        end
      end
      ST_PREIGN: begin
        if (flame) begin
          ns = ST_LOCKOUT;
        end else if (r.t >= SHORT_PREIGN_TICKS) begin
          ns = ST_SAFETY;
        end
      end
      ST_SAFETY: begin
        if (r.t >= SAFETY_TICKS) begin
          ns = flame ? ST_POSTIGN : ST_LOCKOUT;
        end
      end
      ST_POSTIGN: begin
        if (r.t >= SECOND_STAGE_TICKS) begin
          ns = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hfreq) begin
          ns = max_mon ? ST_HF_OPEN : ST_HIGH;
        end
      end
      ST_HF_OPEN: begin
        if (!hfreq) begin
          ns = ST_RUN;
        end else if (dmax) begin
          ns = ST_HIGH;
        end else if (tmo) begin
          ns = ST_LOCKOUT;
        end
      end
      ST_HIGH: begin
        if (!hfreq) begin
          ns = ST_RUN;
        end
      end
      ST_LOCKOUT: begin
        if (rst_any) begin
          ns = ST_RESET_WAIT;
        end
      end
      ST_RESET_WAIT: begin
        if (r.t >= SAFETY_TICKS) begin
          ns = ST_IDLE;
        end
      end
      default: ns = ST_LOCKOUT;
    endcase
    // flame loss while running
    if (running && !flame) begin
      ns = recycle ? ST_IDLE : ST_LOCKOUT;
    end
    // demand withdrawn outside lockout and reset wait ends the cycle, unless this cycle locks out
    if (!dem && r.st != ST_LOCKOUT && r.st != ST_RESET_WAIT && ns != ST_LOCKOUT) begin
      ns = ST_IDLE;
    end
    // supply loss keeps only a lockout
    if (!pwr && r.st != ST_LOCKOUT) begin
      ns = ST_IDLE;
    end
    next_r.st = ns;
    if (ns != r.st) begin
      next_r.t = 10'h000;
    end

    // outputs follow the next state so valves drop on the same edge
    next_r.motor = pwr && ns != ST_IDLE && ns != ST_LOCKOUT && ns != ST_RESET_WAIT;
    if (short_pi) begin
      next_r.ign = pwr && (ns == ST_PREIGN || ns == ST_SAFETY ||
                   (ns == ST_POSTIGN && next_r.t < POSTIGN_TICKS));
    end else begin
      next_r.ign = pwr && (ns == ST_WAIT_OPEN || ns == ST_PREPURGE || ns == ST_WAIT_MIN ||
                   ns == ST_SAFETY || (ns == ST_POSTIGN && next_r.t < POSTIGN_TICKS));
    end
    next_r.dcmd = pwr && (ns == ST_WAIT_OPEN || ns == ST_PREPURGE ||
                  ns == ST_HF_OPEN || ns == ST_HIGH);
    next_r.v1 = pwr && (ns == ST_SAFETY || ns == ST_POSTIGN || ns == ST_RUN ||
                ns == ST_HF_OPEN || ns == ST_HIGH);
    next_r.v2 = pwr && ns == ST_HIGH;
    next_r.hf_en = pwr && (ns == ST_RUN || ns == ST_HF_OPEN || ns == ST_HIGH);
    next_r.lamp = pwr && ns == ST_LOCKOUT;

    // axi4-lite write channel
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_ok = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_ok && r.w_ok && !r.bvalid) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      unique case ({r.aw_addr[3:2], 2'b00})
        CONFIG_OFS: begin
          if (r.wstrb[0]) begin
            next_r.cfg = r.wdata[5:0];
          end
        end
        CONTROL_OFS: begin
          next_r.sw_reset = r.wstrb[0] & r.wdata[CTL_REMOTE_RESET];
        end
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    next_r.awready = !next_r.aw_ok && !next_r.bvalid;
    next_r.wready = !next_r.w_ok && !next_r.bvalid;

    // axi4-lite read channel
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      unique case ({s_axi_araddr[3:2], 2'b00})
        CONFIG_OFS: next_r.rdata = {26'h0000000, r.cfg};
        CONTROL_OFS: next_r.rdata = 32'h00000000;
        STATUS_OFS: next_r.rdata = {12'h000, r.s2, r.lamp, r.hf_en, r.v2, r.v1,
                                    r.dcmd, r.ign, r.motor, 1'b0, 4'(r.st)};
        TIMER_OFS: next_r.rdata = {22'h000000, r.t};
        default: begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_r.arready = !next_r.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.cfg <= CONFIG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // port drive straight from flops
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign motor_hold_relay = r.motor;
  assign ignition = r.ign;
  assign damper_open_cmd = r.dcmd;
  assign first_stage_valve = r.v1;
  assign second_stage_valve = r.v2;
  assign high_flame_enable = r.hf_en;
  assign lockout_relay = r.lamp;
  assign remote_lockout_lamp = r.lamp;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_demand_starts: assert property (r.st == ST_IDLE && dem && pwr |=> r.motor)
    else $error("demand did not start motor");
  a_stray_light: assert property (
    r.st == ST_PREPURGE && flame |=> r.st == ST_LOCKOUT && !r.v1)
    else $error("stray light did not lock out");
  a_no_flame_lock: assert property (
    r.st == ST_SAFETY && r.t >= SAFETY_TICKS && !flame |=> r.st == ST_LOCKOUT && !r.v1)
    else $error("missing flame did not lock out");
  // lamp is registered from last cycle's supply level, so judge it by that level
  a_lockout_lamp: assert property (
    r.st == ST_LOCKOUT && $past(pwr) |-> r.lamp && !r.v1 && !r.motor)
    else $error("lockout outputs wrong");
  a_lockout_holds: assert property (r.st == ST_LOCKOUT && !rst_any |=> r.st == ST_LOCKOUT)
    else $error("lockout left without reset");
  a_recycle_loss: assert property (
    running && !flame && recycle && pwr |=> !r.v1 && !r.v2 && r.st == ST_IDLE)
    else $error("recycle did not restart");
  a_direct_loss: assert property (running && !flame && !recycle |=> r.st == ST_LOCKOUT)
    else $error("direct lockout missed");
  a_v2_after_max: assert property (r.st == ST_HF_OPEN && !dmax |=> !r.v2)
    else $error("second stage opened early");
  a_reset_restart: assert property (
    r.st == ST_RESET_WAIT && r.t >= SAFETY_TICKS |=> r.st == ST_IDLE)
    else $error("no restart after reset");
  // all three damper waits share one timeout; this checks the open and minimum waits
  a_damper_timeout: assert property (
    (r.st == ST_WAIT_OPEN && !dmax || r.st == ST_WAIT_MIN && !dmin && !flame) &&
    tmo && dem && pwr |=> r.st == ST_LOCKOUT)
    else $error("damper timeout ignored");

  c_high_flame: cover property (r.st == ST_RUN ##[1:300] r.v2);
  c_lockout_reset: cover property (r.st == ST_LOCKOUT ##1 r.st == ST_RESET_WAIT);
  c_stray: cover property (r.st == ST_PREPURGE && flame);
endmodule

/* File: verilog/burner_pkg.sv */
// constants and register map of the burner start sequencer
package burner_pkg;
  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int PREPURGE_MS = 30_000;
  localparam int SHORT_PREIGN_MS = 2_000;
  localparam int SAFETY_MS = 5_000;
  localparam int POSTIGN_MS = 7_500;
  localparam int SECOND_STAGE_MS = 11_500;
  localparam int DAMPER_MS = 60_000;
  localparam logic [9:0] PREPURGE_TICKS = 10'(PREPURGE_MS / TICK_MS);
  localparam logic [9:0] SHORT_PREIGN_TICKS = 10'(SHORT_PREIGN_MS / TICK_MS);
  localparam logic [9:0] SAFETY_TICKS = 10'(SAFETY_MS / TICK_MS);
  localparam logic [9:0] POSTIGN_TICKS = 10'(POSTIGN_MS / TICK_MS);
  localparam logic [9:0] SECOND_STAGE_TICKS = 10'(SECOND_STAGE_MS / TICK_MS);
  localparam logic [9:0] DAMPER_TICKS = 10'(DAMPER_MS / TICK_MS);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam logic [3:0] CONFIG_OFS = 4'h0;
  localparam logic [3:0] CONTROL_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] TIMER_OFS = 4'hc;
  localparam logic [5:0] CONFIG_RESET = 6'h00;
  localparam int CFG_RECYCLE_CUT = 0;
  localparam int CFG_DIRECT_LINK = 1;
  localparam int CFG_DAMPER_LO = 2;
  localparam int CFG_TMO_DISABLE = 4;
  localparam int CFG_SHORT_PREIGN = 5;
  localparam int CTL_REMOTE_RESET = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // synchronised input positions
  // ----------------------------------------------------------------
  localparam int IN_DEMAND = 0;
  localparam int IN_FLAME = 1;
  localparam int IN_DMAX = 2;
  localparam int IN_DMIN = 3;
  localparam int IN_HFREQ = 4;
  localparam int IN_BUTTON = 5;
  localparam int IN_REMOTE = 6;
  localparam int IN_SUPPLY = 7;
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_OPEN, ST_PREPURGE, ST_WAIT_MIN, ST_PREIGN, ST_SAFETY,
    ST_POSTIGN, ST_RUN, ST_HF_OPEN, ST_HIGH, ST_LOCKOUT, ST_RESET_WAIT
  } seq_state_t;
endpackage

/* File: dv/burner_partner.sv */
// far-side model: air damper with end switches and a flame detector
`timescale 1ns/1ps
module burner_partner (
  input wire logic aclk,
  input wire logic damper_open_cmd,
  input wire logic first_stage_valve,
  input wire logic flame_ok,
  input wire logic stray_light,
  input wire logic damper_stuck,
  output logic damper_max,
  output logic damper_min,
  output logic flame_present
);
  logic [3:0] pos = 4'h0;
  // ------------------------
  // damper travel
  // ------------------------
  // eight clocks end to end; a stuck damper stays where it is and never moves toward either end
  always @(posedge aclk) begin
    if (!damper_stuck && damper_open_cmd && pos != 4'h8) pos <= pos + 4'h1;
    if (!damper_stuck && !damper_open_cmd && pos != 4'h0) pos <= pos - 4'h1;
  end
  // end switches; flame only with fuel released, or stray light
  assign damper_max = (pos == 4'h8);
  assign damper_min = (pos == 4'h0);
  assign flame_present = stray_light | (flame_ok & first_stage_valve);
endmodule

/* File: dv/burner_start_sequencer_tb.sv */
// self-checking bench for the burner start sequencer
`timescale 1ns/1ps
module burner_start_sequencer_tb;
  import burner_pkg::*;
  localparam int TCK = 4;
  typedef struct {
    logic [5:0] cfg;
    logic fl;
    seq_state_t st;
    int pp;
    int ig;
  } row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic heat_demand = 1'b0, flame_ok = 1'b0, stray_light = 1'b0, damper_stuck = 1'b0;
  logic high_flame_request = 1'b0, reset_button = 1'b0, remote_reset = 1'b0, supply_ok = 1'b1;
  logic flame_present, damper_max, damper_min, motor_hold_relay, ignition, damper_open_cmd;
  logic first_stage_valve, second_stage_valve, high_flame_enable, lockout_relay;
  logic remote_lockout_lamp;
  int err_count = 0, cmp_count = 0, cyc = 0, t_m = 0, t_i = 0, t_v1 = 0, t_hf = 0, t_lk = 0;
  int dt, ex, tv, t_if = 0;
  row_t rows [6] = '{
    '{6'h00, 1'b1, ST_RUN, PREPURGE_TICKS, 0},
    '{6'h00, 1'b0, ST_LOCKOUT, PREPURGE_TICKS, 0},
    '{6'h04, 1'b1, ST_RUN, 0, 0},
    '{6'h08, 1'b1, ST_RUN, 0, 0},
    '{6'h0c, 1'b1, ST_RUN, 0, 0},
    '{6'h20, 1'b1, ST_RUN, PREPURGE_TICKS + SHORT_PREIGN_TICKS, PREPURGE_TICKS}
  };
  // 25 mhz clock
  always #20 aclk = ~aclk;
  burner_start_sequencer #(.TICK_CYCLES(TCK)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .heat_demand, .flame_present,
    .damper_max, .damper_min, .high_flame_request, .reset_button, .remote_reset, .supply_ok,
    .motor_hold_relay, .ignition, .damper_open_cmd, .first_stage_valve, .second_stage_valve,
    .high_flame_enable, .lockout_relay, .remote_lockout_lamp);
  burner_partner far (.aclk, .damper_open_cmd, .first_stage_valve, .flame_ok, .stray_light,
    .damper_stuck, .damper_max, .damper_min, .flame_present);
  // clock count at rising edges of motor, ignition, valve 1, high flame and lockout, and at ignition fall
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if ($rose(motor_hold_relay)) t_m <= cyc;
    if ($rose(ignition)) t_i <= cyc;
    if ($fell(ignition)) t_if <= cyc;
    if ($rose(first_stage_valve)) t_v1 <= cyc;
    if ($rose(high_flame_enable)) t_hf <= cyc;
    if ($rose(lockout_relay)) t_lk <= cyc;
  end
  // ------------------------
  // checks and bus tasks
  // ------------------------
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_st(input string nm, input seq_state_t e, input logic [3:0] g);
    cmp(nm, 32'(e), 32'(g));
  endtask
  task automatic tally_and_finish;
    $display("errors %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang(input string nm);
    cmp(nm, 32'h0, 32'h1);
    tally_and_finish();
  endtask
  function automatic logic near(input int t, input int e);
    return t >= e - TCK - 4 && t <= e + TCK + 4;
  endfunction
  // write and read leave one edge free so a strobe is never set twice at once
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 60) hang("write wait");
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 60) hang("read wait");
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // poll the state field until it shows st
  task automatic wait_st(input seq_state_t st, input int lim);
    int n = 0;
    d = 32'hffff_ffff;
    while (d[3:0] !== st) begin
      axi_rd(STATUS_OFS);
      n++;
      if (n > lim) hang("state wait");
    end
  endtask
  task automatic rst;
    heat_demand <= 1'b0;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic go(input logic [5:0] cfg, input logic fl, input seq_state_t st);
    rst();
    axi_wr(CONFIG_OFS, {26'h0, cfg});
    flame_ok <= fl;
    heat_demand <= 1'b1;
    wait_st(st, 1500);
  endtask
  // ------------------------
  // scenarios
  // ------------------------
  initial begin
    foreach (rows[i]) begin
      go(rows[i].cfg, rows[i].fl, rows[i].st);
      cmp("valve1", 32'(rows[i].fl), 32'(first_stage_valve));
      cmp("lamp", 32'(!rows[i].fl), 32'(lockout_relay));
      cmp("ignition", 32'h1, 32'(near(t_i - t_m, rows[i].ig * TCK)));
      if (rows[i].pp == 0) continue;
      cmp("pre-purge", 32'h1, 32'(near(t_v1 - t_m, rows[i].pp * TCK)));
      dt = rows[i].fl ? t_hf - t_v1 : t_lk - t_v1;
      ex = rows[i].fl ? SAFETY_TICKS + SECOND_STAGE_TICKS : SAFETY_TICKS;
      cmp("after fuel", 32'h1, 32'(near(dt, ex * TCK)));
      // ignition stops 7.5 s after the safety interval, or at lockout
      ex = rows[i].fl ? SAFETY_TICKS + POSTIGN_TICKS : SAFETY_TICKS;
      cmp("ignition off", 32'h1, 32'(near(t_if - t_v1, ex * TCK)));
    end
    // reset in mid-run, defaults, refused writes
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    cmp("outputs", 32'h0, 32'({motor_hold_relay, ignition, first_stage_valve, lockout_relay}));
    rst();
    axi_rd(CONFIG_OFS);
    cmp("config", 32'(CONFIG_RESET), d);
    axi_rd(CONTROL_OFS);
    cmp("control", 32'h0, d);
    axi_wr(STATUS_OFS, 32'h1);
    cmp("status wr", 32'(RESP_SLVERR), 32'(r));
    axi_wr(TIMER_OFS, 32'h1);
    cmp("timer wr", 32'(RESP_SLVERR), 32'(r));
    // lockout through supply loss, then button, remote pin, remote register
    go(6'h00, 1'b0, ST_LOCKOUT);
    cmp("lamps", 32'h3, 32'({lockout_relay, remote_lockout_lamp}));
    supply_ok <= 1'b0;
    repeat (8) @(posedge aclk);
    supply_ok <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(STATUS_OFS);
    cmp_st("lock kept", ST_LOCKOUT, d[3:0]);
    for (int k = 0; k < 3; k++) begin
      wait_st(ST_LOCKOUT, 1500);
      if (k == 0) reset_button <= 1'b1;
      if (k == 1) remote_reset <= 1'b1;
      if (k == 2) axi_wr(CONTROL_OFS, 32'h1);
      repeat (8) @(posedge aclk);
      reset_button <= 1'b0;
      remote_reset <= 1'b0;
      wait_st(ST_RESET_WAIT, 100);
      wait_st(ST_PREPURGE, 200);
      cmp("lamp off", 32'h0, 32'(lockout_relay));
    end
    // supply loss while running restarts normally
    go(6'h00, 1'b1, ST_RUN);
    supply_ok <= 1'b0;
    repeat (8) @(posedge aclk);
    supply_ok <= 1'b1;
    wait_st(ST_PREPURGE, 100);
    // flame loss: cfg 0 direct, 1 repeat-cycle, 3 link forces direct again
    for (int k = 0; k < 3; k++) begin
      go(6'(k + k / 2), 1'b1, ST_RUN);
      flame_ok <= 1'b0;
      repeat (8) @(posedge aclk);
      cmp("fuel cut", 32'h0, 32'(first_stage_valve));
      wait_st(k == 1 ? ST_PREPURGE : ST_LOCKOUT, 400);
    end
    // stray light in pre-purge
    go(6'h00, 1'b1, ST_PREPURGE);
    tv = t_v1;
    stray_light <= 1'b1;
    wait_st(ST_LOCKOUT, 100);
    stray_light <= 1'b0;
    cmp("no fuel", 32'(tv), 32'(t_v1));
    // damper never reaches its end
    damper_stuck <= 1'b1;
    go(6'h04, 1'b1, ST_WAIT_OPEN);
    wait_st(ST_LOCKOUT, 1000);
    cmp("damper time", 32'h1, 32'(near(t_lk - t_m, DAMPER_TICKS * TCK)));
    go(6'h14, 1'b1, ST_WAIT_OPEN);
    repeat (700 * TCK) @(posedge aclk);
    axi_rd(STATUS_OFS);
    cmp_st("no timeout", ST_WAIT_OPEN, d[3:0]);
    damper_stuck <= 1'b0;
    wait_st(ST_PREPURGE, 100);
    // high flame with damper maximum monitored
    go(6'h04, 1'b1, ST_RUN);
    high_flame_request <= 1'b1;
    wait_st(ST_HIGH, 100);
    cmp("high", 32'h7, 32'({damper_max, second_stage_valve, damper_open_cmd}));
    repeat (200) @(posedge aclk);
    axi_rd(STATUS_OFS);
    cmp_st("steady", ST_HIGH, d[3:0]);
    high_flame_request <= 1'b0;
    tally_and_finish();
  end
endmodule
